//--- logic/cgc_pkg.sv
// Constants, register map and types of the counter gate/compare/latch block
package cgc_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W  = 32;
  localparam int HW_CH  = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PULSE_STEP_NS = 2000000;
  localparam int PULSE_STEP_CYC = PULSE_STEP_NS / CLK_PERIOD_NS;
  // Per-channel register block: channel in addr[6:5], word in addr[4:2]
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_CFG    = 3'h1;
  localparam logic [2:0] REG_LOAD   = 3'h2;
  localparam logic [2:0] REG_CMP    = 3'h3;
  localparam logic [2:0] REG_COUNT  = 3'h4;
  localparam logic [2:0] REG_LATCH  = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam int CH_LSB  = 5;
  localparam int REG_LSB = 2;
  localparam int MAP_MSB = 6;
  // Control bits
  localparam int CTRL_SOFTWARE_GATE  = 0;
  localparam int CTRL_OUT_EN   = 1;
  localparam int CTRL_MANUAL   = 2;
  localparam int CTRL_CLR_CMP  = 3;
  localparam int CTRL_CLR_OVUF = 4;
  localparam int CTRL_W        = 3;
  // Status bits
  localparam int ST_CMP  = 0;
  localparam int ST_OUT  = 1;
  localparam int ST_OVF  = 2;
  localparam int ST_UNF  = 3;
  localparam int ST_RUN  = 4;
  // Event enable bits in cfg.irq_en
  localparam int EV_CMP = 0;
  localparam int EV_OVF = 1;
  localparam int EV_UNF = 2;
  localparam logic [31:0] CFG_MASK  = 32'h07ff_ffff;
  localparam logic [31:0] LOAD_RST  = 32'h0000_0000;
  localparam logic [31:0] CMP_RST   = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX   = 32'h7fff_ffff;
  localparam logic [31:0] CNT_MIN   = 32'h8000_0000;
  localparam logic [7:0]  HYST_MIN_ON = 8'h02;
  typedef enum logic [1:0] {OUT_NONE, OUT_LEVEL, OUT_PULSE, OUT_RSVD}
    cgc_out_mode_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN, DIR_RSVD} cgc_dir_t;
  typedef struct packed {
    logic [4:0]    rsvd;
    logic [2:0]    irq_en;
    logic [7:0]    pulse_dur;
    logic [7:0]    hyst;
    logic          one_shot;
    logic          hardware_gate_en;
    cgc_dir_t      dir;
    logic          le_mode;
    cgc_out_mode_t out_mode;
    logic          gate_int;
  } cgc_cfg_t;
endpackage

//--- logic/cgc_counter.sv
// Counter channels with gate, comparator, hysteresis and pulse output; latch on channel 3 only
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module cgc_counter
  import cgc_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_STEP_CYC
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Field pins
  input  wire logic [NUM_CH-1:0] cnt_up_pin,
  input  wire logic [NUM_CH-1:0] cnt_dn_pin,
  input  wire logic              hardware_gate,
  input  wire logic              latch_pin,
  output logic      [NUM_CH-1:0] field_out,
  output logic      [NUM_CH-1:0] hw_event
);
  logic [NUM_CH-1:0] up_s1, up_s2, up_d, dn_s1, dn_s2, dn_d;
  logic              hw_s1, hw_s2, hw_d, lt_s1, lt_s2, lt_d;
  logic [1:0]        bus_ch;
  logic [2:0]        bus_reg;
  logic              bus_bad, bus_wr;
  logic [31:0]       next_prdata;
  logic [31:0]       rd_word [NUM_CH][7];

  // Pins cross in through two flops before any edge logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {up_s1, up_s2, up_d} <= '0;
      {dn_s1, dn_s2, dn_d} <= '0;
      {hw_s1, hw_s2, hw_d, lt_s1, lt_s2, lt_d} <= '0;
    end else if (clk_en) begin
      up_s1 <= cnt_up_pin;
      up_s2 <= up_s1;
      up_d  <= up_s2;
      dn_s1 <= cnt_dn_pin;
      dn_s2 <= dn_s1;
      dn_d  <= dn_s2;
      hw_s1 <= hardware_gate;
      hw_s2 <= hw_s1;
      hw_d  <= hw_s2;
      lt_s1 <= latch_pin;
      lt_s2 <= lt_s1;
      lt_d  <= lt_s2;
    end
  end

  assign bus_ch  = paddr[MAP_MSB:CH_LSB];
  assign bus_reg = paddr[CH_LSB-1:REG_LSB];
  always_comb begin
    if (paddr[11:MAP_MSB+1] != '0) begin
      bus_bad = 1'b1;
    end else if (paddr[REG_LSB-1:0] != '0) begin
      bus_bad = 1'b1;
    end else if (bus_reg > REG_STATUS) begin
      bus_bad = 1'b1;
    end else begin
      bus_bad = 1'b0;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & bus_bad;
  assign bus_wr  = psel & penable & pwrite & ~bus_bad;
  assign next_prdata = bus_bad ? '0 : rd_word[bus_ch][bus_reg];

  // Read data is captured in the setup cycle so the access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (clk_en && psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [CTRL_W-1:0] ctrl;
    cgc_cfg_t          cfg;
    logic [31:0]       load_val, cmp_val, count, latch_val;
    logic              sw_d, auto_closed, hw_rose, last_up;
    logic              hyst_on, res_q, eval_d, p_act, cmp_flag;
    logic              ovf_flag, unf_flag, do_q, ev_q;
    logic [7:0]        h_lat, p_steps;
    logic [31:0]       p_presc;
    logic              wr_c, sw, sw_rise, hw_en, hw_lvl, hw_rise;
    logic              gate_raw, reopen, run, reload, st_up, st_dn;
    logic              ovf_ev, unf_ev, cond, eval, hit, dir_ok;
    logic              p_start, set_cmp, clr_ok, is_lvl, is_pls;
    logic signed [32:0] lo, hi, cnt_s;

    assign wr_c = bus_wr && bus_ch == 2'(g);
    assign sw = ctrl[CTRL_SOFTWARE_GATE];
    assign sw_rise = sw & ~sw_d;
    assign hw_en = (g == HW_CH) && cfg.hardware_gate_en;
    assign hw_lvl = hw_s2;
    assign hw_rise = hw_en & hw_s2 & ~hw_d;
    assign gate_raw = hw_en ? (sw & hw_lvl) : sw;
    assign reopen = hw_en ? ((hw_rise & sw) | (sw_rise & hw_rose & hw_lvl))
                          : sw_rise;
    assign run = gate_raw & (~auto_closed | reopen);
    // Software rise with hw high only continues; hw rise may reload
    assign reload = ~cfg.gate_int & (~auto_closed | reopen) &
                    (hw_en ? (hw_rise & sw) : sw_rise);
    assign st_up = run & up_s2[g] & ~up_d[g] & ~(dn_s2[g] & ~dn_d[g]);
    assign st_dn = run & dn_s2[g] & ~dn_d[g] & ~(up_s2[g] & ~up_d[g]);
    assign ovf_ev = st_up && count == CNT_MAX && !reload;
    assign unf_ev = st_dn && count == CNT_MIN && !reload;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl <= '0;
        cfg <= '0;
        load_val <= LOAD_RST;
        cmp_val <= CMP_RST;
      end else if (clk_en && wr_c) begin
        if (bus_reg == REG_CTRL) begin
          ctrl <= pwdata[CTRL_W-1:0];
        end else if (bus_reg == REG_CFG) begin
          cfg <= cgc_cfg_t'(pwdata & CFG_MASK);
        end else if (bus_reg == REG_LOAD) begin
          load_val <= pwdata;
        end else if (bus_reg == REG_CMP) begin
          cmp_val <= pwdata;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sw_d <= 1'b0;
        auto_closed <= 1'b0;
        hw_rose <= 1'b0;
      end else if (clk_en) begin
        sw_d <= sw;
        if (cfg.one_shot && (ovf_ev || unf_ev)) begin
          auto_closed <= 1'b1;
          hw_rose <= 1'b0;
        end else if (auto_closed && reopen) begin
          auto_closed <= 1'b0;
          hw_rose <= 1'b0;
        end else if (auto_closed && hw_rise) begin
          hw_rose <= 1'b1;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count <= '0;
        last_up <= 1'b1;
      end else if (clk_en) begin
        if (reload) begin
          count <= load_val;
        end else if (st_up) begin
          count <= count + 32'h0000_0001;
          last_up <= 1'b1;
        end else if (st_dn) begin
          count <= count - 32'h0000_0001;
          last_up <= 1'b0;
        end
      end
    end

    if (g == HW_CH) begin : g_latch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          latch_val <= '0;
        end else if (clk_en && run && lt_s2 && !lt_d) begin
          latch_val <= count;
        end
      end
    end else begin : g_nolatch
      assign latch_val = '0;
    end

    // Comparator; band kept one bit wider so it cannot wrap
    assign is_lvl = cfg.out_mode == OUT_LEVEL;
    assign is_pls = cfg.out_mode == OUT_PULSE;
    assign cnt_s = 33'($signed(count));
    assign lo = 33'($signed(cmp_val)) - 33'(h_lat);
    assign hi = 33'($signed(cmp_val)) + 33'(h_lat);
    always_comb begin
      if (is_lvl) begin
        cond = cfg.le_mode ? ($signed(count) <= $signed(cmp_val))
                           : ($signed(count) >= $signed(cmp_val));
      end else begin
        cond = count == cmp_val;
      end
    end
    assign eval = hyst_on ? res_q : cond;
    assign hit = eval & ~eval_d;
    assign dir_ok = cfg.dir == DIR_NONE || cfg.dir == DIR_RSVD ||
                    (cfg.dir == DIR_UP) == last_up;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hyst_on <= 1'b0;
        res_q <= 1'b0;
        h_lat <= '0;
        eval_d <= 1'b0;
      end else if (clk_en) begin
        eval_d <= eval;
        if (hyst_on) begin
          if (cnt_s < lo || cnt_s > hi) begin
            hyst_on <= 1'b0;
            res_q <= cond;
          end
        end else begin
          res_q <= cond;
          if (cond && !res_q && cfg.hyst >= HYST_MIN_ON) begin
            hyst_on <= 1'b1;
            h_lat <= cfg.hyst;
          end
        end
      end
    end

    // Pulse timer: 2 ms steps, duration taken only at the start
    assign p_start = is_pls && cfg.pulse_dur != '0 && hit && dir_ok &&
                     !p_act;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        p_act <= 1'b0;
        p_steps <= '0;
        p_presc <= '0;
      end else if (clk_en) begin
        if (p_start) begin
          p_act <= 1'b1;
          p_steps <= cfg.pulse_dur;
          p_presc <= '0;
        end else if (p_act) begin
          if (p_presc == 32'(PULSE_CYC - 1)) begin
            p_presc <= '0;
            p_steps <= p_steps - 8'h01;
            if (p_steps == 8'h01) begin
              p_act <= 1'b0;
            end
          end else begin
            p_presc <= p_presc + 32'h0000_0001;
          end
        end
      end
    end

    assign set_cmp = is_lvl ? eval
                   : is_pls && (p_start || (cfg.pulse_dur == '0 && eval &&
                                            dir_ok));
    assign clr_ok = is_lvl ? !eval : !p_act;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_flag <= 1'b0;
        ovf_flag <= 1'b0;
        unf_flag <= 1'b0;
        do_q <= 1'b0;
        ev_q <= 1'b0;
      end else if (clk_en) begin
        // A set in the clearing cycle wins
        if (!is_lvl && !is_pls) begin
          cmp_flag <= 1'b0;
        end else if (set_cmp) begin
          cmp_flag <= 1'b1;
        end else if (wr_c && bus_reg == REG_CTRL && pwdata[CTRL_CLR_CMP] &&
                     clr_ok) begin
          cmp_flag <= 1'b0;
        end
        // Wraps inside an active band are suppressed
        if (ovf_ev && !hyst_on) begin
          ovf_flag <= 1'b1;
        end else if (wr_c && bus_reg == REG_CTRL && pwdata[CTRL_CLR_OVUF]) begin
          ovf_flag <= 1'b0;
        end
        if (unf_ev && !hyst_on) begin
          unf_flag <= 1'b1;
        end else if (wr_c && bus_reg == REG_CTRL && pwdata[CTRL_CLR_OVUF]) begin
          unf_flag <= 1'b0;
        end
        if (is_lvl) begin
          do_q <= ctrl[CTRL_OUT_EN] & eval;
        end else if (is_pls) begin
          do_q <= ctrl[CTRL_OUT_EN] &
                  (cfg.pulse_dur == '0 ? eval & dir_ok : p_act);
        end else begin
          do_q <= ctrl[CTRL_MANUAL];
        end
        ev_q <= (cfg.irq_en[EV_CMP] & (is_lvl | is_pls) & hit & dir_ok) |
                (cfg.irq_en[EV_OVF] & ovf_ev & ~hyst_on) |
                (cfg.irq_en[EV_UNF] & unf_ev & ~hyst_on);
      end
    end

    assign field_out[g] = do_q;
    assign hw_event[g] = ev_q;
    assign rd_word[g][REG_CTRL]   = 32'(ctrl);
    assign rd_word[g][REG_CFG]    = cfg;
    assign rd_word[g][REG_LOAD]   = load_val;
    assign rd_word[g][REG_CMP]    = cmp_val;
    assign rd_word[g][REG_COUNT]  = count;
    assign rd_word[g][REG_LATCH]  = latch_val;
    assign rd_word[g][REG_STATUS] = {27'h0, run, unf_flag, ovf_flag,
                                     do_q & (is_lvl | is_pls), cmp_flag};
  end
endmodule // cgc_counter

//--- test/cgc_chk.sv
// Assertion checker for the counter gate/compare/latch block
`timescale 1ns/1ns
module cgc_chk
  import cgc_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_STEP_CYC
) (
  // Clock, reset, enable
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Field pins
  input wire logic [NUM_CH-1:0] cnt_up_pin,
  input wire logic [NUM_CH-1:0] cnt_dn_pin,
  input wire logic              hardware_gate,
  input wire logic              latch_pin,
  input wire logic [NUM_CH-1:0] field_out,
  input wire logic [NUM_CH-1:0] hw_event
);
  // Shadow of channel 0 and 1 settings, snooped from completed writes
  logic [31:0] cfg0;
  logic        man0;
  logic        wr0;
  logic        none0;
  logic [2:0]  en1;
  logic        rd_acc;
  assign wr0    = psel && penable && pwrite && !pslverr && clk_en;
  assign none0  = cfg0[2:1] != 2'b01 && cfg0[2:1] != 2'b10;
  assign rd_acc = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0 <= '0;
      man0 <= 1'b0;
      en1  <= '0;
    end else if (wr0 && paddr == 12'h024) begin
      en1 <= pwdata[26:24];
    end else if (wr0 && paddr == 12'h004) begin
      cfg0 <= pwdata;
    end else if (wr0 && paddr == 12'h000) begin
      man0 <= pwdata[CTRL_MANUAL];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready)
    else $error("pready low");
  err_access_only_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  err_read_zero_a: assert property (rd_acc && pslverr |-> prdata == '0)
    else $error("refused read not zero");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  manual_out_a: assert property ($past(none0) |-> field_out[0] == $past(man0))
    else $error("plain output not following manual level");
  none_flags_a: assert property (rd_acc && paddr == 12'h018 && none0
    && $past(none0) && $past(none0, 2) |-> prdata[1:0] == 2'b00)
    else $error("flags set in plain output mode");
  latch_only_ch3_a: assert property (rd_acc && paddr[4:2] == REG_LATCH
    && paddr[6:5] != 2'd3 |-> prdata == '0)
    else $error("latch on a channel without one");
  event_enable_a: assert property (hw_event[1] |->
    ($past(en1) | $past(en1, 2)) != 3'h0)
    else $error("event without enable");
endmodule // cgc_chk

bind cgc_counter cgc_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cnt_up_pin(cnt_up_pin), .cnt_dn_pin(cnt_dn_pin),
  .hardware_gate(hardware_gate), .latch_pin(latch_pin),
  .field_out(field_out), .hw_event(hw_event));

//--- test/cgc_field.sv
// Field-side model: count pulses, hardware gate and latch pin
`timescale 1ns/1ns
module cgc_field
  import cgc_pkg::*;
(
  // Clock
  input  wire logic              pclk,
  // Pins toward the block
  output logic      [NUM_CH-1:0] cnt_up_pin,
  output logic      [NUM_CH-1:0] cnt_dn_pin,
  output logic                   hardware_gate,
  output logic                   latch_pin
);
  initial begin
    cnt_up_pin    = '0;
    cnt_dn_pin    = '0;
    hardware_gate = 1'b0;
    latch_pin     = 1'b0;
  end
  // Each level is held at least 3 clocks so the 2-flop sync never misses an edge
  task step(input int ch, input bit up, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (up)
        cnt_up_pin[ch] <= 1'b1;
      else
        cnt_dn_pin[ch] <= 1'b1;
      repeat (3) @(posedge pclk);
      cnt_up_pin[ch] <= 1'b0;
      cnt_dn_pin[ch] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask
  task set_gate(input bit v);
    @(posedge pclk);
    hardware_gate <= v;
    repeat (6) @(posedge pclk);
  endtask
  task latch_rise();
    @(posedge pclk);
    latch_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    latch_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // cgc_field

//--- test/cgc_counter_bench.sv
// Self-checking bench for the counter gate/compare/latch block
`timescale 1ns/1ns
module cgc_counter_bench;
  import cgc_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        err;
  } cgc_row_t;
  localparam cgc_row_t ROWS [9] = '{
    '{12'h024, 32'hffffffff, 32'h07ffffff, 1'b0},
    '{12'h06c, 32'ha5a55a5a, 32'ha5a55a5a, 1'b0},
    '{12'h048, 32'h12345678, 32'h12345678, 1'b0},
    '{12'h020, 32'h0000001a, 32'h00000002, 1'b0},
    '{12'h010, 32'hffffffff, 32'h00000000, 1'b0},
    '{12'h014, 32'hffffffff, 32'h00000000, 1'b0},
    '{12'h01c, 32'h00000001, 32'h00000000, 1'b1},
    '{12'h002, 32'h00000001, 32'h00000000, 1'b1},
    '{12'h080, 32'h00000001, 32'h00000000, 1'b1}};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              hardware_gate, latch_pin, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [NUM_CH-1:0] up_pin, dn_pin, field_out, hw_event;
  int                errors, n_tests, n_ev, n_hi;
  cgc_counter #(.PULSE_CYC(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnt_up_pin(up_pin), .cnt_dn_pin(dn_pin),
    .hardware_gate(hardware_gate), .latch_pin(latch_pin),
    .field_out(field_out), .hw_event(hw_event));
  cgc_field u_fld (
    .pclk(pclk), .cnt_up_pin(up_pin), .cnt_dn_pin(dn_pin),
    .hardware_gate(hardware_gate), .latch_pin(latch_pin));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (hw_event[1] === 1'b1) n_ev++;
    if (field_out[2] === 1'b1) n_hi++;
  end
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Entered and left just after a rising edge; psel drops for one cycle
  task automatic apb(input logic [11:0] a, input logic w, logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    n_tests = 0;
    n_ev = 0;
    n_hi = 0;
    do_reset();
    foreach (ROWS[i]) begin
      rd(ROWS[i].a);
      chk("reset value", 32'h0, q);
      wr(ROWS[i].a, ROWS[i].d);
      chk("refusal", {31'h0, ROWS[i].err}, {31'h0, e});
      rd(ROWS[i].a);
      chk("readback", ROWS[i].x, q);
    end
    do_reset();
    wr(12'h008, 32'd10);
    wr(12'h000, 32'h1);
    u_fld.step(0, 1, 3);
    rd(12'h010);
    chk("count after open", 32'd13, q);
    wr(12'h000, 32'h0);
    u_fld.step(0, 1, 2);
    rd(12'h010);
    chk("count while closed", 32'd13, q);
    wr(12'h000, 32'h1);
    rd(12'h010);
    chk("abort reload", 32'd10, q);
    wr(12'h004, 32'h1);
    u_fld.step(0, 1, 2);
    wr(12'h000, 32'h0);
    wr(12'h000, 32'h1);
    rd(12'h010);
    chk("interrupt resume", 32'd12, q);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h4);
    repeat (3) @(posedge pclk);
    chk("plain output", 32'h1, {31'h0, field_out[0]});
    rd(12'h018);
    chk("plain flags", 32'h0, {30'h0, q[1:0]});
    wr(12'h02c, 32'd5);
    wr(12'h028, 32'd3);
    wr(12'h024, 32'h01000002);
    wr(12'h020, 32'h3);
    u_fld.step(1, 1, 2);
    chk("level out", 32'h1, {31'h0, field_out[1]});
    chk("compare events", 32'd1, n_ev);
    wr(12'h020, 32'hb);
    rd(12'h038);
    chk("flag held", 32'h1, {31'h0, q[0]});
    u_fld.step(1, 0, 1);
    chk("level out low", 32'h0, {31'h0, field_out[1]});
    wr(12'h020, 32'hb);
    rd(12'h038);
    chk("flag cleared", 32'h0, {31'h0, q[0]});
    wr(12'h024, 32'h01000302);
    u_fld.step(1, 1, 1);
    u_fld.step(1, 0, 1);
    chk("band holds output", 32'h1, {31'h0, field_out[1]});
    u_fld.step(1, 0, 3);
    chk("band exit output", 32'h0, {31'h0, field_out[1]});
    wr(12'h04c, 32'd2);
    wr(12'h044, 32'h00080004);
    wr(12'h040, 32'h3);
    u_fld.step(2, 1, 2);
    wr(12'h040, 32'hb);
    rd(12'h058);
    chk("flag during pulse", 32'h1, {31'h0, q[0]});
    u_fld.step(2, 0, 1);
    u_fld.step(2, 1, 1);
    repeat (40) @(posedge pclk);
    chk("pulse length", 32'd32, n_hi);
    wr(12'h040, 32'hb);
    rd(12'h058);
    chk("flag after pulse", 32'h0, {31'h0, q[0]});
    wr(12'h044, 32'h00000004);
    repeat (2) @(posedge pclk);
    chk("zero pulse held", 32'h1, {31'h0, field_out[2]});
    u_fld.step(2, 1, 1);
    chk("zero pulse ends", 32'h0, {31'h0, field_out[2]});
    wr(12'h064, 32'h40);
    wr(12'h068, 32'd100);
    wr(12'h060, 32'h1);
    u_fld.step(3, 1, 1);
    rd(12'h070);
    chk("gate needs both", 32'h0, q);
    u_fld.set_gate(1'b1);
    u_fld.step(3, 1, 1);
    rd(12'h070);
    chk("hardware rise reload", 32'd101, q);
    wr(12'h060, 32'h0);
    wr(12'h060, 32'h1);
    u_fld.latch_rise();
    rd(12'h074);
    chk("latched count", 32'd101, q);
    u_fld.set_gate(1'b0);
    u_fld.set_gate(1'b1);
    rd(12'h074);
    chk("latch kept", 32'd101, q);
    u_fld.set_gate(1'b0);
    wr(12'h064, 32'h0);
    u_fld.step(3, 1, 1);
    rd(12'h070);
    chk("software gate only", 32'd101, q);
    wr(12'h068, 32'h7fffffff);
    wr(12'h064, 32'hc0);
    u_fld.set_gate(1'b1);
    u_fld.step(3, 1, 2);
    wr(12'h060, 32'h0);
    wr(12'h060, 32'h1);
    u_fld.step(3, 1, 1);
    rd(12'h070);
    chk("auto close held", 32'h80000000, q);
    u_fld.set_gate(1'b0);
    u_fld.set_gate(1'b1);
    rd(12'h070);
    chk("hardware reopen", 32'h7fffffff, q);
    report_and_stop();
  end
endmodule // cgc_counter_bench
